// ---- include/sffe_pkg.sv ----
// sffe_pkg: constants, opcodes, phase states and erase kinds of the serial flash front end.
// assumes: one 100 MHz system clock; the spi clock and chip select arrive as plain pins.
//
// Summary of operation
// - array is 8,388,608 bytes, linearly addressed
// - 128 blocks of 64 kilobytes
// - 256 half blocks, two per block
// - 2,048 sectors of 4 kilobytes, smallest erase
// - 32,768 pages of 256 bytes; program stays in page
// - programming only clears bits, one to zero
// - erase by sector, half block, block or chip, never page
// - sector n spans n*4096 to n*4096+4095
// - clock modes 0 and 3 both work
// - input sampled on rising serial clock edge
// - output launched on falling serial clock edge
// - 3Bh dual output read, BBh dual io read
// - dual reads drive lines 0,1 only when outputting
// - other instructions, except EBh and all of 38h mode, use one line each way
// - EBh quad io read uses lines 0 to 3
// - 38h enters full four-line command mode
// - chip select high floats every output line
// - first instruction only after a select falling edge
// - write protect function only outside quad operation
// - line 3 is pause or reset outside quad

package sffe_pkg;

  // array geometry
  localparam int SFFE_ADDR_W = 23;
  localparam int SFFE_PAGE_LSB = 8;
  localparam int SFFE_SECTOR_LSB = 12;
  localparam int SFFE_HALF_LSB = 15;
  localparam int SFFE_BLOCK_LSB = 16;

  // ------------------------------------------------------------
  // opcodes
  // ------------------------------------------------------------
  localparam logic [7:0] SFFE_OP_READ = 8'h03;
  localparam logic [7:0] SFFE_OP_FAST = 8'h0B;
  localparam logic [7:0] SFFE_OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] SFFE_OP_DUAL_IO = 8'hBB;
  localparam logic [7:0] SFFE_OP_QUAD_IO = 8'hEB;
  localparam logic [7:0] SFFE_OP_ENTER_FOUR = 8'h38;
  localparam logic [7:0] SFFE_OP_EXIT_FOUR = 8'hFF;
  localparam logic [7:0] SFFE_OP_PROGRAM = 8'h02;
  localparam logic [7:0] SFFE_OP_SECTOR_ER = 8'h20;
  localparam logic [7:0] SFFE_OP_HALF_ER = 8'h52;
  localparam logic [7:0] SFFE_OP_BLOCK_ER = 8'hD8;
  localparam logic [7:0] SFFE_OP_CHIP_ER_A = 8'hC7;
  localparam logic [7:0] SFFE_OP_CHIP_ER_B = 8'h60;

  // ------------------------------------------------------------
  // bit counts, lanes, dummy clocks and pin enables
  // ------------------------------------------------------------
  localparam logic [4:0] SFFE_CMD_BITS = 5'h08;
  localparam logic [4:0] SFFE_ADDR_BITS = 5'h18;
  localparam logic [4:0] SFFE_BYTE_MASK = 5'h07;
  localparam logic [4:0] SFFE_LANES_1 = 5'h01;
  localparam logic [4:0] SFFE_LANES_2 = 5'h02;
  localparam logic [4:0] SFFE_LANES_4 = 5'h04;
  localparam logic [4:0] SFFE_DUMMY_NONE = 5'h00;
  localparam logic [4:0] SFFE_DUMMY_FAST = 5'h08;
  localparam logic [4:0] SFFE_DUMMY_DUAL_IO = 5'h04;
  localparam logic [4:0] SFFE_DUMMY_QUAD_IO = 5'h06;
  localparam logic [3:0] SFFE_OE_NONE = 4'h0;
  localparam logic [3:0] SFFE_OE_STD = 4'h2;
  localparam logic [3:0] SFFE_OE_DUAL = 4'h3;
  localparam logic [3:0] SFFE_OE_QUAD = 4'hF;

  typedef enum logic [2:0] {
    SFFE_ST_IDLE, SFFE_ST_CMD, SFFE_ST_ADDR, SFFE_ST_DUMMY,
    SFFE_ST_READ, SFFE_ST_WDATA, SFFE_ST_HALT
  } sffe_state_type;

  typedef enum logic [2:0] {
    SFFE_ER_NONE, SFFE_ER_SECTOR, SFFE_ER_HALF, SFFE_ER_BLOCK, SFFE_ER_CHIP
  } sffe_erase_type;

endpackage : sffe_pkg

// ---- src/sffe_sync.sv ----
// sffe_sync: two-flop synchroniser for a group of independent pin levels.
// assumes: each bit is a slow level or clock, sampled many times per change.
`timescale 1ns/1ns

module sffe_sync #(
  parameter int WIDTH = 6
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sffe_sync_type;

  sffe_sync_type r, n;

  // first stage feeds only the second stage
  always_comb begin
    n.meta = async_in;
    n.stable = r.meta;
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign sync_out = r.stable;

endmodule : sffe_sync

// ---- src/sffe_addr_decode.sv ----
// sffe_addr_decode: splits a byte address into block, half block, sector and page.
// assumes: address is already wrapped into the array; outputs lag the address by one clock.
`timescale 1ns/1ns

module sffe_addr_decode
  import sffe_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [SFFE_ADDR_W-1:0] addr_in,
  output logic [SFFE_ADDR_W-SFFE_BLOCK_LSB-1:0] block_out,
  output logic [SFFE_ADDR_W-SFFE_HALF_LSB-1:0] half_out,
  output logic [SFFE_ADDR_W-SFFE_SECTOR_LSB-1:0] sector_out,
  output logic [SFFE_ADDR_W-SFFE_PAGE_LSB-1:0] page_out
);
  typedef struct packed {
    logic [SFFE_ADDR_W-SFFE_BLOCK_LSB-1:0] block;
    logic [SFFE_ADDR_W-SFFE_HALF_LSB-1:0] half;
    logic [SFFE_ADDR_W-SFFE_SECTOR_LSB-1:0] sector;
    logic [SFFE_ADDR_W-SFFE_PAGE_LSB-1:0] page;
  } sffe_dec_type;

  sffe_dec_type r, n;

  // plain slicing: every unit is a power of two, so no divider is needed
  always_comb begin
    n.block = addr_in[SFFE_ADDR_W-1:SFFE_BLOCK_LSB];
    n.half = addr_in[SFFE_ADDR_W-1:SFFE_HALF_LSB];
    n.sector = addr_in[SFFE_ADDR_W-1:SFFE_SECTOR_LSB];
    n.page = addr_in[SFFE_ADDR_W-1:SFFE_PAGE_LSB];
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign block_out = r.block;
  assign half_out = r.half;
  assign sector_out = r.sector;
  assign page_out = r.page;

  half_in_block_a: assert property (@(posedge clock_in) disable iff (reset_in)
    half_out[SFFE_ADDR_W-SFFE_HALF_LSB-1:1] == block_out)
    else $error("half block does not sit inside its block");
  sector_span_a: assert property (@(posedge clock_in) disable iff (reset_in)
    sector_out == $past(addr_in[SFFE_ADDR_W-1:SFFE_SECTOR_LSB]))
    else $error("sector index does not match address");

endmodule : sffe_addr_decode

// ---- src/sffe_front_end.sv ----
// sffe_front_end: serial flash pin front end; decodes opcodes, addresses and data
// phases on one, two or four lines and drives the array side with strobes.
// assumes: spi clock and chip select come from a host at most ~1/8 of clock_in;
// the array returns array_rdata_in for array_addr_out within two clocks.
`timescale 1ns/1ns

module sffe_front_end
  import sffe_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic spi_clk_in,
  input wire logic chip_sel_n_in,
  input wire logic io_line_0_in,
  input wire logic io_line_1_in,
  input wire logic io_line_2_in,
  input wire logic io_line_3_in,
  input wire logic reset_function_sel_in,
  input wire logic [7:0] array_rdata_in,
  output logic io_line_0_out,
  output logic io_line_1_out,
  output logic io_line_2_out,
  output logic io_line_3_out,
  output logic io_line_0_oe_out,
  output logic io_line_1_oe_out,
  output logic io_line_2_oe_out,
  output logic io_line_3_oe_out,
  output logic [SFFE_ADDR_W-1:0] array_addr_out,
  output logic program_strobe_out,
  output logic [7:0] program_data_out,
  output logic erase_strobe_out,
  output logic [2:0] erase_kind_out,
  output logic write_protect_n_out,
  output logic full_four_line_mode_out,
  output logic [SFFE_ADDR_W-SFFE_BLOCK_LSB-1:0] block_out,
  output logic [SFFE_ADDR_W-SFFE_HALF_LSB-1:0] half_out,
  output logic [SFFE_ADDR_W-SFFE_SECTOR_LSB-1:0] sector_out,
  output logic [SFFE_ADDR_W-SFFE_PAGE_LSB-1:0] page_out
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    sffe_state_type state;
    logic clk_prev;
    logic cs_prev;
    logic armed;
    logic four_line;
    logic [7:0] op;
    logic [23:0] sh;
    logic [4:0] cnt;
    logic [7:0] tx;
    logic [SFFE_ADDR_W-1:0] addr;
    logic prog_stb;
    logic [7:0] prog_data;
    logic er_stb;
    sffe_erase_type er_kind;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    logic wp_n;
  } sffe_core_type;

  sffe_core_type r, n;
  logic [5:0] pins_sync;
  logic s_clk;
  logic s_cs_n;
  logic [3:0] s_io;
  logic rise;
  logic fall;
  logic quad_act;
  logic hold_act;
  logic hw_reset_act;
  logic [4:0] lanes;
  logic [4:0] cnt_step;
  logic [23:0] sh_in;
  logic [7:0] out_byte;

  // ------------------------------------------------------------
  // pin synchronisers and edge finding
  // ------------------------------------------------------------
  sffe_sync #(.WIDTH(6)) u_sync (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .async_in({io_line_3_in, io_line_2_in, io_line_1_in, io_line_0_in,
               chip_sel_n_in, spi_clk_in}),
    .sync_out(pins_sync)
  );

  assign s_clk = pins_sync[0];
  assign s_cs_n = pins_sync[1];
  assign s_io = pins_sync[5:2];
  // either idle level works: in mode 3 the first edge seen is a falling one,
  // which no input phase acts on
  assign rise = s_clk & ~r.clk_prev;
  assign fall = ~s_clk & r.clk_prev;

  // ------------------------------------------------------------
  // lane selection per phase
  // ------------------------------------------------------------
  // quad use turns lines 2 and 3 into data; their pin functions then rest
  assign quad_act = r.four_line | ((r.op == SFFE_OP_QUAD_IO) &&
                    (r.state != SFFE_ST_IDLE) && (r.state != SFFE_ST_CMD));
  assign hold_act = ~quad_act & ~reset_function_sel_in & ~s_io[3] & ~s_cs_n;
  assign hw_reset_act = ~quad_act & reset_function_sel_in & ~s_io[3];

  always_comb begin
    lanes = SFFE_LANES_1;
    case (r.state)
      SFFE_ST_CMD, SFFE_ST_WDATA, SFFE_ST_HALT: begin
        if (r.four_line) begin
          lanes = SFFE_LANES_4;
        end
      end
      SFFE_ST_ADDR: begin
        if (r.four_line || r.op == SFFE_OP_QUAD_IO) begin
          lanes = SFFE_LANES_4;
        end else if (r.op == SFFE_OP_DUAL_IO) begin
          lanes = SFFE_LANES_2;
        end
      end
      SFFE_ST_READ: begin
        if (r.four_line || r.op == SFFE_OP_QUAD_IO) begin
          lanes = SFFE_LANES_4;
        end else if (r.op == SFFE_OP_DUAL_IO || r.op == SFFE_OP_DUAL_OUT) begin
          lanes = SFFE_LANES_2;
        end
      end
      default: lanes = SFFE_LANES_1;
    endcase
  end

  // msb first on every width; line 0 carries the lowest bit of each group
  always_comb begin
    case (lanes)
      SFFE_LANES_4: sh_in = {r.sh[19:0], s_io};
      SFFE_LANES_2: sh_in = {r.sh[21:0], s_io[1:0]};
      default: sh_in = {r.sh[22:0], s_io[0]};
    endcase
  end

  assign cnt_step = 5'(r.cnt + lanes);
  assign out_byte = (r.cnt == SFFE_DUMMY_NONE) ? array_rdata_in : r.tx;

  function automatic logic [4:0] sffe_dummy(input logic [7:0] op);
    case (op)
      SFFE_OP_FAST, SFFE_OP_DUAL_OUT: return SFFE_DUMMY_FAST;
      SFFE_OP_DUAL_IO: return SFFE_DUMMY_DUAL_IO;
      SFFE_OP_QUAD_IO: return SFFE_DUMMY_QUAD_IO;
      default: return SFFE_DUMMY_NONE;
    endcase
  endfunction : sffe_dummy

  // ------------------------------------------------------------
  // phase sequencer
  // ------------------------------------------------------------
  always_comb begin
    n = r;
    n.prog_stb = 1'b0;
    n.er_stb = 1'b0;
    n.clk_prev = s_clk;
    n.cs_prev = s_cs_n;
    n.wp_n = quad_act ? 1'b1 : s_io[2];
    if (s_cs_n) begin
      n.armed = 1'b1;
    end
    if (hw_reset_act) begin
      // the reset pin drops a transfer outside quad use; four-line mode masks the pin and stays on
      n.state = SFFE_ST_IDLE;
      n.four_line = 1'b0;
    end else if (s_cs_n) begin
      // deselect closes the frame; whole-byte commands act only now
      if (r.state == SFFE_ST_HALT && r.cnt == SFFE_DUMMY_NONE) begin
        case (r.op)
          SFFE_OP_SECTOR_ER: n.er_kind = SFFE_ER_SECTOR;
          SFFE_OP_HALF_ER: n.er_kind = SFFE_ER_HALF;
          SFFE_OP_BLOCK_ER: n.er_kind = SFFE_ER_BLOCK;
          SFFE_OP_CHIP_ER_A, SFFE_OP_CHIP_ER_B: n.er_kind = SFFE_ER_CHIP;
          default: n.er_kind = SFFE_ER_NONE;
        endcase
        n.er_stb = (n.er_kind != SFFE_ER_NONE);
        if (r.op == SFFE_OP_ENTER_FOUR) begin
          n.four_line = 1'b1;
        end
        if (r.op == SFFE_OP_EXIT_FOUR && r.four_line) begin
          n.four_line = 1'b0;
        end
      end
      n.state = SFFE_ST_IDLE;
    end else if (!hold_act) begin
      case (r.state)
        SFFE_ST_IDLE: begin
          if (!r.cs_prev || !r.armed) begin
            n.state = SFFE_ST_IDLE;
          end else begin
            n.state = SFFE_ST_CMD;
            n.cnt = '0;
          end
        end
        SFFE_ST_CMD: begin
          if (rise) begin
            n.sh = sh_in;
            n.cnt = cnt_step;
            if (cnt_step == SFFE_CMD_BITS) begin
              n.op = sh_in[7:0];
              n.cnt = '0;
              case (sh_in[7:0])
                SFFE_OP_READ, SFFE_OP_FAST, SFFE_OP_DUAL_OUT, SFFE_OP_DUAL_IO,
                SFFE_OP_QUAD_IO, SFFE_OP_PROGRAM, SFFE_OP_SECTOR_ER,
                SFFE_OP_HALF_ER, SFFE_OP_BLOCK_ER: n.state = SFFE_ST_ADDR;
                default: n.state = SFFE_ST_HALT;
              endcase
            end
          end
        end
        SFFE_ST_ADDR: begin
          if (rise) begin
            n.sh = sh_in;
            n.cnt = cnt_step;
            if (cnt_step == SFFE_ADDR_BITS) begin
              // top address bit lies beyond the array and wraps
              n.addr = sh_in[SFFE_ADDR_W-1:0];
              n.cnt = '0;
              if (r.op == SFFE_OP_PROGRAM) begin
                n.state = SFFE_ST_WDATA;
              end else if (r.op == SFFE_OP_SECTOR_ER || r.op == SFFE_OP_HALF_ER ||
                           r.op == SFFE_OP_BLOCK_ER) begin
                n.state = SFFE_ST_HALT;
              end else if (sffe_dummy(r.op) == SFFE_DUMMY_NONE) begin
                n.state = SFFE_ST_READ;
              end else begin
                n.state = SFFE_ST_DUMMY;
              end
            end
          end
        end
        SFFE_ST_DUMMY: begin
          if (rise) begin
            n.cnt = 5'(r.cnt + SFFE_LANES_1);
            if (5'(r.cnt + SFFE_LANES_1) == sffe_dummy(r.op)) begin
              n.state = SFFE_ST_READ;
              n.cnt = '0;
            end
          end
        end
        SFFE_ST_READ: begin
          // a byte is fetched at its first falling edge, then shifted out
          if (fall) begin
            case (lanes)
              SFFE_LANES_4: n.io_out = out_byte[7:4];
              SFFE_LANES_2: n.io_out = {2'h0, out_byte[7:6]};
              default: n.io_out = {2'h0, out_byte[7], 1'b0};
            endcase
            n.tx = out_byte << lanes;
            n.cnt = cnt_step;
            if (cnt_step == SFFE_CMD_BITS) begin
              n.cnt = '0;
              n.addr = SFFE_ADDR_W'(r.addr + 1'b1);
            end
          end
        end
        SFFE_ST_WDATA: begin
          if (rise) begin
            n.sh = sh_in;
            n.cnt = cnt_step;
            if (cnt_step == SFFE_CMD_BITS) begin
              n.cnt = '0;
              n.prog_stb = 1'b1;
              n.prog_data = sh_in[7:0] & array_rdata_in;
              // the byte pointer wraps inside the page, never into the next one
              n.addr[SFFE_PAGE_LSB-1:0] = 8'(r.addr[SFFE_PAGE_LSB-1:0] + 1'b1);
            end
          end
        end
        SFFE_ST_HALT: begin
          // counts stray bits so only whole-byte frames reach execution
          if (rise) begin
            n.cnt = cnt_step & SFFE_BYTE_MASK;
          end
        end
        default: n.state = SFFE_ST_IDLE;
      endcase
    end
    // drive only in the output phase; deselect or pause floats the lines
    // lines turn around at a falling edge only, after the host has let go of them
    if (r.state == SFFE_ST_READ && n.state == SFFE_ST_READ && !s_cs_n && !hold_act &&
        (fall || |r.io_oe)) begin
      case (lanes)
        SFFE_LANES_4: n.io_oe = SFFE_OE_QUAD;
        SFFE_LANES_2: n.io_oe = SFFE_OE_DUAL;
        default: n.io_oe = SFFE_OE_STD;
      endcase
    end else begin
      n.io_oe = SFFE_OE_NONE;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ------------------------------------------------------------
  // array address decode and outputs
  // ------------------------------------------------------------
  sffe_addr_decode u_decode (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .addr_in(r.addr),
    .block_out(block_out),
    .half_out(half_out),
    .sector_out(sector_out),
    .page_out(page_out)
  );

  assign io_line_0_out = r.io_out[0];
  assign io_line_1_out = r.io_out[1];
  assign io_line_2_out = r.io_out[2];
  assign io_line_3_out = r.io_out[3];
  assign io_line_0_oe_out = r.io_oe[0];
  assign io_line_1_oe_out = r.io_oe[1];
  assign io_line_2_oe_out = r.io_oe[2];
  assign io_line_3_oe_out = r.io_oe[3];
  assign array_addr_out = r.addr;
  assign program_strobe_out = r.prog_stb;
  assign program_data_out = r.prog_data;
  assign erase_strobe_out = r.er_stb;
  assign erase_kind_out = r.er_kind;
  assign write_protect_n_out = r.wp_n;
  assign full_four_line_mode_out = r.four_line;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  deselect_float_a: assert property (s_cs_n |=> r.io_oe == SFFE_OE_NONE)
    else $error("output driven while deselected");
  armed_first_a: assert property ((r.state == SFFE_ST_IDLE && !r.armed) |=>
    r.state == SFFE_ST_IDLE)
    else $error("instruction started before a select edge");
  cmd_on_rise_a: assert property ((r.state == SFFE_ST_CMD && n.state == SFFE_ST_ADDR)
    |-> rise)
    else $error("opcode taken without a rising edge");
  launch_fall_a: assert property ($changed(r.io_out) |-> $past(fall))
    else $error("output changed off a falling edge");
  std_oe_a: assert property ((|r.io_oe && !r.four_line &&
    (r.op == SFFE_OP_READ || r.op == SFFE_OP_FAST)) |-> r.io_oe == SFFE_OE_STD)
    else $error("standard read drove more than one line");
  dual_oe_a: assert property ((|r.io_oe && !r.four_line &&
    (r.op == SFFE_OP_DUAL_IO || r.op == SFFE_OP_DUAL_OUT)) |-> r.io_oe == SFFE_OE_DUAL)
    else $error("dual read lane enables wrong");
  quad_oe_a: assert property ((|r.io_oe && r.op == SFFE_OP_QUAD_IO)
    |-> r.io_oe == SFFE_OE_QUAD)
    else $error("quad read lane enables wrong");
  oe_read_a: assert property (|r.io_oe |-> $past(r.state) == SFFE_ST_READ)
    else $error("lines driven outside the output phase");
  page_wrap_a: assert property (r.prog_stb |=>
    r.addr[SFFE_ADDR_W-1:SFFE_PAGE_LSB] == $past(r.addr[SFFE_ADDR_W-1:SFFE_PAGE_LSB]))
    else $error("program crossed a page");
  clear_only_a: assert property (r.prog_stb |->
    (r.prog_data & ~$past(array_rdata_in)) == 8'h00)
    else $error("program would set a bit");
  four_enter_a: assert property ($rose(r.four_line) |-> r.op == SFFE_OP_ENTER_FOUR)
    else $error("four-line mode entered without its opcode");
  no_page_erase_a: assert property (r.er_stb |-> (r.er_kind != SFFE_ER_NONE &&
    $past(r.state) == SFFE_ST_HALT && $past(s_cs_n)))
    else $error("erase strobe without a legal unit");

endmodule : sffe_front_end

// ---- verif/sffe_host_model.sv ----
// sffe_host_model: spi host that frames transfers on one, two or four lines.
// assumes: the device samples on rising and launches on falling clock edges.
`timescale 1ns/1ns

module sffe_host_model (
  input wire logic [3:0] dut_d_in,
  input wire logic [3:0] dut_oe_in,
  output logic spi_clk_out,
  output logic chip_sel_n_out,
  output logic [3:0] line_out
);
  logic [3:0] drv_r = 4'h0;
  logic [3:0] oe_r = 4'h0;
  logic idle_r = 1'b0;
  logic pause_r = 1'b0;
  // released lines float high through the board pull-ups; pause_r pulls line 3 low
  assign line_out = ((dut_oe_in & dut_d_in) | (~dut_oe_in & ((oe_r & drv_r) | ~oe_r))) &
    ~{pause_r, 3'h0};
  initial begin
    spi_clk_out = 1'b0;
    chip_sel_n_out = 1'b1;
  end
  // park the clock at the idle level of the mode before selecting
  task automatic start(input logic cpol);
    idle_r = cpol;
    spi_clk_out = cpol;
    #100;
    chip_sel_n_out = 1'b0;
    #100;
  endtask : start
  // msb group first; data only moves while the clock is low
  task automatic send(input int lanes, input int n, input logic [31:0] v);
    for (int k = n - lanes; k >= 0; k -= lanes) begin
      spi_clk_out = 1'b0;
      oe_r = 4'((1 << lanes) - 1);
      drv_r = 4'(v >> k);
      #62;
      spi_clk_out = 1'b1;
      #63;
    end
    oe_r = 4'h0;
  endtask : send
  // sample late in the low phase, after the device has launched
  task automatic recv(input int lanes, input int n, output logic [31:0] v);
    v = 32'h0;
    for (int k = 0; k < n; k += lanes) begin
      spi_clk_out = 1'b0;
      #62;
      if (lanes == 1) v = {v[30:0], line_out[1]};
      else v = (v << lanes) | 32'(line_out & 4'((1 << lanes) - 1));
      spi_clk_out = 1'b1;
      #63;
    end
  endtask : recv
  task automatic stop();
    spi_clk_out = idle_r;
    #40;
    chip_sel_n_out = 1'b1;
    #300;
  endtask : stop
endmodule : sffe_host_model

// ---- verif/tb.sv ----
// tb: drives the flash front end through the host model and judges its pins.
// assumes: array byte at an address is its low byte xor 5Ah.
`timescale 1ns/1ns

module tb;
  import sffe_pkg::*;
  logic clock_in, reset_in, reset_function_sel_in, program_strobe_out, erase_strobe_out;
  logic write_protect_n_out, full_four_line_mode_out;
  wire spi_clk_in, chip_sel_n_in, io_line_0_in, io_line_1_in, io_line_2_in, io_line_3_in;
  logic io_line_0_out, io_line_1_out, io_line_2_out, io_line_3_out;
  logic io_line_0_oe_out, io_line_1_oe_out, io_line_2_oe_out, io_line_3_oe_out;
  logic [SFFE_ADDR_W-1:0] array_addr_out;
  logic [7:0] array_rdata_in, program_data_out, last_pd;
  logic [2:0] erase_kind_out, last_kind;
  logic [6:0] block_out;
  logic [7:0] half_out;
  logic [10:0] sector_out;
  logic [14:0] page_out;
  int error_cnt = 0, cmp_count = 0, n_prog = 0, n_erase = 0;
  assign array_rdata_in = array_addr_out[7:0] ^ 8'h5A;
  sffe_front_end i_dut (.clock_in, .reset_in, .spi_clk_in, .chip_sel_n_in, .io_line_0_in,
    .io_line_1_in, .io_line_2_in, .io_line_3_in, .reset_function_sel_in, .array_rdata_in,
    .io_line_0_out, .io_line_1_out, .io_line_2_out, .io_line_3_out, .io_line_0_oe_out,
    .io_line_1_oe_out, .io_line_2_oe_out, .io_line_3_oe_out, .array_addr_out,
    .program_strobe_out, .program_data_out, .erase_strobe_out, .erase_kind_out,
    .write_protect_n_out, .full_four_line_mode_out, .block_out, .half_out, .sector_out,
    .page_out);
  sffe_host_model i_host (.dut_d_in({io_line_3_out, io_line_2_out, io_line_1_out,
    io_line_0_out}), .dut_oe_in({io_line_3_oe_out, io_line_2_oe_out, io_line_1_oe_out,
    io_line_0_oe_out}), .spi_clk_out(spi_clk_in), .chip_sel_n_out(chip_sel_n_in),
    .line_out({io_line_3_in, io_line_2_in, io_line_1_in, io_line_0_in}));
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // count strobes here so a one-cycle pulse is never missed
  always @(posedge clock_in) begin
    if (program_strobe_out === 1'b1) begin
      n_prog++;
      last_pd = program_data_out;
    end
    if (erase_strobe_out === 1'b1) begin
      n_erase++;
      last_kind = erase_kind_out;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic results();
    if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_read();
    logic [31:0] v;
    i_host.start(1'b0);
    i_host.send(1, 8, 32'h03);
    i_host.send(1, 24, 32'h7FF123);
    i_host.recv(1, 16, v);
    chk("rd data", {8'h23 ^ 8'h5A, 8'h24 ^ 8'h5A}, v);
    chk("rd oe", 4'h2, {io_line_3_oe_out, io_line_2_oe_out, io_line_1_oe_out,
      io_line_0_oe_out});
    i_host.stop();
    chk("idle oe", 0, io_line_1_oe_out);
    chk("block", 7'h7F, block_out);
    chk("half", 8'hFF, half_out);
    chk("sector", 11'h7FF, sector_out);
    chk("page", 15'h7FF1, page_out);
  endtask : t_read
  // pause mid-read: lines float, state is kept, the next byte follows
  task automatic t_hold();
    logic [31:0] v;
    reset_function_sel_in <= 1'b0;
    i_host.start(1'b0);
    i_host.send(1, 8, 32'h03);
    i_host.send(1, 24, 32'h10);
    i_host.recv(1, 8, v);
    chk("hold first", 8'h4A, v);
    chk("pre hold oe", 1, io_line_1_oe_out);
    i_host.pause_r = 1'b1;
    #100;
    chk("hold oe", 0, io_line_1_oe_out);
    i_host.pause_r = 1'b0;
    #100;
    i_host.recv(1, 8, v);
    chk("hold data", 8'h4B, v);
    i_host.stop();
    reset_function_sel_in <= 1'b1;
  endtask : t_hold
  // fast reads: opcode, address on al lanes, dummy clocks, data on dl lanes
  task automatic t_fast(input logic cp, input logic [7:0] op, input int al, input int dm,
      input int dl);
    logic [31:0] v;
    i_host.start(cp);
    i_host.send(1, 8, 32'(op));
    i_host.send(al, 24, 32'h10);
    i_host.send(1, dm, 0);
    chk("pre oe", 0, {io_line_3_oe_out, io_line_2_oe_out, io_line_1_oe_out,
      io_line_0_oe_out});
    i_host.recv(dl, 16, v);
    chk("fast oe", (1 << dl) - 1, {io_line_3_oe_out, io_line_2_oe_out, io_line_1_oe_out,
      io_line_0_oe_out});
    chk("fast data", 32'h4A4B, v);
    chk("wp", 1, write_protect_n_out);
    i_host.stop();
  endtask : t_fast
  // two bytes across the page end wrap back to the page start
  task automatic t_prog();
    int n0;
    n0 = n_prog;
    i_host.start(1'b0);
    i_host.send(1, 32, 32'h020001FF);
    i_host.send(1, 16, 32'hF00F);
    i_host.stop();
    chk("prog n", n0 + 2, n_prog);
    chk("prog data", 8'h0A, last_pd);
    chk("prog page", 15'h001, page_out);
  endtask : t_prog
  task automatic t_erase();
    logic [7:0] ops [5] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
    int n0;
    for (int i = 0; i < 5; i++) begin
      n0 = n_erase;
      i_host.start(1'b1);
      i_host.send(1, 8, 32'(ops[i]));
      if (i < 3) i_host.send(1, 24, 32'h7FF000);
      i_host.stop();
      chk("erase n", n0 + 1, n_erase);
      chk("erase kind", (i < 3) ? i + 1 : 4, last_kind);
    end
  endtask : t_erase
  task automatic t_four();
    i_host.start(1'b0);
    i_host.send(1, 8, 32'h38);
    i_host.stop();
    chk("four on", 1, full_four_line_mode_out);
    i_host.start(1'b0);
    i_host.send(4, 8, 32'hFF);
    i_host.stop();
    chk("four off", 0, full_four_line_mode_out);
  endtask : t_four
  initial begin
    reset_in = 1'b1;
    reset_function_sel_in = 1'b1;
    repeat (6) @(posedge clock_in);
    reset_in <= 1'b0;
    repeat (5) @(posedge clock_in);
    // keep every host pin change off the sampling edge of clock_in
    #2;
    t_read();
    t_hold();
    t_fast(1'b1, 8'h3B, 1, 8, 2);
    t_fast(1'b0, 8'hBB, 2, 4, 2);
    t_fast(1'b0, 8'hEB, 4, 6, 4);
    t_prog();
    t_erase();
    t_four();
    results();
  end
  // the whole run needs well under 100 us of link traffic
  initial begin
    #500000;
    error_cnt++;
    results();
  end
endmodule : tb
